//--- pma_pmd_control_status_regs.v
// attachment control/status registers behind a clause 45 management slave
`include "pma_ctrl_map.vh"

// Summary of operation
// - control bit 15 write reinitialises whole chip
// - reset bit always reads zero, as the frame parser is held in reset while busy
// - control bit 11 enters low power state
// - management access stays alive during powerdown
// - powerdown reset value follows configuration pin
// - control bit 0 loops transmit onto receive
// - status bit 2 latches low until read
// - status bit 1 always reads one
// - devices present low reads 0x8B
// - devices present high reads 0xC000
// - control reset value depends on pins
// - status at device one offset one, resets two
module pma_pmd_control_status_regs #(
  parameter [4:0] PORT_ADDR = 5'h00
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire mdc_i,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe_n_o,
  input wire powerdown_default_pin_i,
  input wire link_up_i,
  input wire [3:0] tx_data_i,
  input wire tx_en_i,
  input wire [3:0] line_rx_data_i,
  input wire line_rx_dv_i,
  output reg [3:0] rx_data_o,
  output reg rx_dv_o,
  output reg [3:0] line_tx_data_o,
  output reg line_tx_en_o,
  output wire chip_reset_o,
  output wire attach_soft_powerdown_o,
  output wire local_loopback_enable_o
);

  localparam [3:0] S_PRE = 4'b0001;
  localparam [3:0] S_HDR = 4'b0010;
  localparam [3:0] S_TA = 4'b0100;
  localparam [3:0] S_DATA = 4'b1000;
  localparam [7:0] RST_CYC = `SOFT_RST_CYC;

  //////////////////////////////////////////////////////////////////////////
  // synchronisers for pins from outside the clock domain
  reg mdc_s1, mdc_s2, mdc_s3;
  reg mdio_s1, mdio_s2;
  reg pin_s1, pin_s2;
  reg link_s1, link_s2;

  always @(posedge clk_sys_i) begin
    mdc_s1 <= mdc_i;
    mdc_s2 <= mdc_s1;
    mdc_s3 <= mdc_s2;
    mdio_s1 <= mdio_i;
    mdio_s2 <= mdio_s1;
    pin_s1 <= powerdown_default_pin_i;
    pin_s2 <= pin_s1;
    link_s1 <= link_up_i;
    link_s2 <= link_s1;
  end

  // mdc and mdio see equal delay, so bit sampled at the rise is aligned
  wire mdc_rise = mdc_s2 & ~mdc_s3;
  wire bit_in = mdio_s2;

  //////////////////////////////////////////////////////////////////////////
  // register state
  reg [7:0] rst_cnt;
  reg [1:0] pin_load;
  reg soft_powerdown;
  reg loopback;
  reg link_ll;
  reg [15:0] reg_addr;
  wire rst_busy = (rst_cnt != 8'h00);
  wire local_rst = rst_i | rst_busy;

  assign chip_reset_o = rst_busy;
  assign attach_soft_powerdown_o = soft_powerdown;
  assign local_loopback_enable_o = loopback;

  function [15:0] reg_read;
    input [15:0] addr;
    input busy;
    input pd;
    input lb;
    input ll;
    begin
      reg_read = 16'h0000;
      case (addr)
        `OFS_CONTROL: begin
          reg_read[`CTL_SOFT_RESET] = busy;
          reg_read[`CTL_SOFT_POWERDOWN] = pd;
          reg_read[`CTL_LOOPBACK] = lb;
        end
        `OFS_STATUS: begin
          reg_read[`STA_LINK_UP] = ll;
          reg_read[`STA_PD_CAPABLE] = 1'b1;
        end
        `OFS_DEVS_LOW: reg_read = `VAL_DEVS_LOW;
        `OFS_DEVS_HIGH: reg_read = `VAL_DEVS_HIGH;
        default: reg_read = 16'h0000;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // management frame parser; runs in powerdown too
  reg [3:0] state;
  reg [5:0] pre_cnt;
  reg [3:0] hdr_cnt;
  reg [4:0] dat_cnt;
  reg [12:0] hdr;
  reg [15:0] wdata;
  reg [15:0] rshift;
  reg ta_first;
  reg reading;
  reg [1:0] op;
  reg for_us;

  wire [12:0] next_hdr = {hdr[11:0], bit_in};
  wire hdr_match = (next_hdr[12] == 1'b0) &&
    (next_hdr[9:5] == PORT_ADDR) && (next_hdr[4:0] == `MMD_DEVAD);
  wire [15:0] next_wdata = {wdata[14:0], bit_in};
  wire frame_end = mdc_rise && (state == S_DATA) &&
    (dat_cnt == `DATA_BITS - 5'd1);
  wire do_write = frame_end && for_us && (op == `OP_WRITE);
  wire status_read = mdc_rise && (state == S_HDR) &&
    (hdr_cnt == `HEADER_BITS - 4'd1) && hdr_match &&
    next_hdr[11] && (reg_addr == `OFS_STATUS);

  always @(posedge clk_sys_i) begin
    if (local_rst) begin
      state <= S_PRE;
      pre_cnt <= 6'd0;
      hdr_cnt <= 4'd0;
      dat_cnt <= 5'd0;
      hdr <= 13'h0000;
      wdata <= 16'h0000;
      rshift <= 16'h0000;
      ta_first <= 1'b0;
      reading <= 1'b0;
      op <= 2'b00;
      for_us <= 1'b0;
      reg_addr <= 16'h0000;
      mdio_o <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end else if (mdc_rise) begin
      case (state)
        S_PRE: begin
          if (bit_in) begin
            if (pre_cnt != `PREAMBLE_BITS) begin
              pre_cnt <= pre_cnt + 6'd1;
            end
          end else if (pre_cnt == `PREAMBLE_BITS) begin
            state <= S_HDR;
            hdr_cnt <= 4'd0;
            hdr <= 13'h0000;
          end else begin
            pre_cnt <= 6'd0;
          end
        end
        S_HDR: begin
          hdr <= next_hdr;
          hdr_cnt <= hdr_cnt + 4'd1;
          if (hdr_cnt == `HEADER_BITS - 4'd1) begin
            op <= next_hdr[11:10];
            for_us <= hdr_match;
            reading <= hdr_match & next_hdr[11];
            rshift <= reg_read(reg_addr, rst_busy, soft_powerdown,
              loopback, link_ll);
            ta_first <= 1'b1;
            state <= S_TA;
          end
        end
        S_TA: begin
          ta_first <= 1'b0;
          if (ta_first) begin
            mdio_oe_n_o <= ~reading;
            mdio_o <= 1'b0;
          end else begin
            mdio_o <= rshift[15];
            rshift <= {rshift[14:0], 1'b0};
            dat_cnt <= 5'd0;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          wdata <= next_wdata;
          dat_cnt <= dat_cnt + 5'd1;
          mdio_o <= rshift[15];
          rshift <= {rshift[14:0], 1'b0};
          if (dat_cnt == `DATA_BITS - 5'd1) begin
            mdio_oe_n_o <= 1'b1;
            mdio_o <= 1'b1;
            pre_cnt <= 6'd0;
            state <= S_PRE;
            if (for_us && (op == `OP_ADDRESS)) begin
              reg_addr <= next_wdata;
            end
            if (for_us && (op == `OP_READ_INC)) begin
              reg_addr <= reg_addr + 16'h0001;
            end
          end
        end
        default: state <= S_PRE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // soft reset counter; hardware reset only clears it
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_cnt <= 8'h00;
    end else if (rst_busy) begin
      rst_cnt <= rst_cnt - 8'h01;
    end else if (do_write && (reg_addr == `OFS_CONTROL) &&
        next_wdata[`CTL_SOFT_RESET]) begin
      rst_cnt <= RST_CYC;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control fields; powerdown reloads from the pin after any reset
  always @(posedge clk_sys_i) begin
    if (local_rst) begin
      pin_load <= `PIN_LOAD_CYC;
      soft_powerdown <= 1'b0;
      loopback <= 1'b0;
    end else if (pin_load != 2'd0) begin
      // the synchroniser needs a few cycles to carry the pin level
      pin_load <= pin_load - 2'd1;
      soft_powerdown <= pin_s2;
    end else if (do_write && (reg_addr == `OFS_CONTROL) &&
        !next_wdata[`CTL_SOFT_RESET]) begin
      soft_powerdown <= next_wdata[`CTL_SOFT_POWERDOWN];
      loopback <= next_wdata[`CTL_LOOPBACK];
    end
  end

  // a drop in the same cycle as the read still clears the bit
  always @(posedge clk_sys_i) begin
    if (local_rst) begin
      link_ll <= 1'b0;
    end else if (status_read) begin
      link_ll <= link_s2;
    end else begin
      link_ll <= link_ll & link_s2;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data path: loopback and powerdown gating
  always @(posedge clk_sys_i) begin
    if (local_rst || soft_powerdown) begin
      rx_data_o <= 4'h0;
      rx_dv_o <= 1'b0;
      line_tx_data_o <= 4'h0;
      line_tx_en_o <= 1'b0;
    end else if (loopback) begin
      rx_data_o <= tx_data_i;
      rx_dv_o <= tx_en_i;
      line_tx_data_o <= 4'h0;
      line_tx_en_o <= 1'b0;
    end else begin
      rx_data_o <= line_rx_data_i;
      rx_dv_o <= line_rx_dv_i;
      line_tx_data_o <= tx_data_i;
      line_tx_en_o <= tx_en_i;
    end
  end

endmodule // pma_pmd_control_status_regs

//--- pma_ctrl_map.vh
// register map, field positions, reset values and timing counts
`ifndef PMA_CTRL_MAP_VH
`define PMA_CTRL_MAP_VH

`define MMD_DEVAD 5'h01
`define OFS_CONTROL 16'h0000
`define OFS_STATUS 16'h0001
`define OFS_DEVS_LOW 16'h0005
`define OFS_DEVS_HIGH 16'h0006

`define CTL_SOFT_RESET 15
`define CTL_SOFT_POWERDOWN 11
`define CTL_LOOPBACK 0
`define STA_LINK_UP 2
`define STA_PD_CAPABLE 1

`define RST_CONTROL 16'h0000
`define RST_STATUS 16'h0002
`define VAL_DEVS_LOW 16'h008B
`define VAL_DEVS_HIGH 16'hC000

`define OP_ADDRESS 2'b00
`define OP_WRITE 2'b01
`define OP_READ_INC 2'b10
`define OP_READ 2'b11

`define PREAMBLE_BITS 6'd32
`define HEADER_BITS 4'd13
`define DATA_BITS 5'd16

// soft reset lasts 640 ns of the 4 ns system clock
`define SOFT_RST_CYC 8'hA0
`define PIN_LOAD_CYC 2'd3

`endif

//--- pma_pmd_control_status_regs_properties.sv
// checker for the attachment control/status block
`include "pma_ctrl_map.vh"
module pma_pmd_control_status_regs_props (
  input wire clk_sys_i,
  input wire rst_i,
  input wire powerdown_default_pin_i,
  input wire [3:0] tx_data_i,
  input wire [3:0] line_rx_data_i,
  input wire [3:0] rx_data_o,
  input wire line_tx_en_o,
  input wire mdio_o,
  input wire mdio_oe_n_o,
  input wire chip_reset_o,
  input wire attach_soft_powerdown_o,
  input wire local_loopback_enable_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire pd = attach_soft_powerdown_o;
  wire lb = local_loopback_enable_o;
  reg [8:0] rc;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // counts busy cycles of the soft reset, cleared whenever idle
  always @(posedge clk_sys_i)
    rc <= (rst_i || !chip_reset_o) ? 9'h000 : rc + 9'h001;
  // two-cycle antecedents: the data path is registered behind the controls
  AST_LB_RX: assert property ((lb && !pd) ##1 (lb && !pd) |->
    rx_data_o == $past(tx_data_i)) else $error("loopback rx wrong");
  AST_LB_TXQ: assert property (lb ##1 lb |-> !line_tx_en_o)
    else $error("line tx live in loopback");
  // soft reset also clears the controls, so it is kept out of normal mode
  AST_NORM: assert property ((!lb && !pd && !chip_reset_o) ##1
    (!lb && !pd && !chip_reset_o) |->
    rx_data_o == $past(line_rx_data_i)) else $error("normal rx wrong");
  AST_PD_Q: assert property (pd ##1 pd |-> rx_data_o == 4'h0 &&
    !line_tx_en_o) else $error("data path live in powerdown");
  AST_SR_LEN: assert property ($fell(chip_reset_o) && !$past(rst_i) |->
    rc == `SOFT_RST_CYC) else $error("soft reset length wrong");
  AST_SR_CLR: assert property (chip_reset_o ##1 chip_reset_o |->
    !lb && !pd) else $error("controls kept in soft reset");
  AST_PIN: assert property ($fell(rst_i) && $stable(powerdown_default_pin_i)
    ##4 1 |-> pd == powerdown_default_pin_i) else $error("pin default lost");
  AST_TA0: assert property ($fell(mdio_oe_n_o) |-> !mdio_o)
    else $error("turnaround not zero");
  cover property ($fell(chip_reset_o));
  cover property ($fell(mdio_oe_n_o));
  cover property (lb && !pd);
endmodule // pma_pmd_control_status_regs_props
bind pma_pmd_control_status_regs pma_pmd_control_status_regs_props props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_data_i(tx_data_i),
  .powerdown_default_pin_i(powerdown_default_pin_i),
  .line_rx_data_i(line_rx_data_i), .rx_data_o(rx_data_o),
  .line_tx_en_o(line_tx_en_o), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o),
  .chip_reset_o(chip_reset_o),
  .attach_soft_powerdown_o(attach_soft_powerdown_o),
  .local_loopback_enable_o(local_loopback_enable_o));

//--- mdio_host_model.sv
// management host: clause 45 frames on the serial management pins
module mdio_host_model (
  input wire line_i,
  output logic mdc_o,
  output logic oe_o,
  output logic d_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    mdc_o = 1'b0;
    oe_o = 1'b0;
    d_o = 1'b1;
  end
  // clock stands low between frames; data sampled just before each rise
  task automatic frame(input [1:0] op, input [4:0] dev, input [15:0] wd,
    output [15:0] rd);
    reg [63:0] v;
    integer s;
    v = {32'hFFFF_FFFF, 2'b00, op, 5'h00, dev, 2'b10, wd};
    rd = 16'h0000;
    #0.7;
    for (s = 0; s < 64; s++) begin
      oe_o = !op[1] || s < 46;
      d_o = v[63 - s];
      #40;
      if (s >= 48)
        rd = {rd[14:0], line_i};
      mdc_o = 1'b1;
      #40;
      mdc_o = 1'b0;
    end
    oe_o = 1'b0;
    #400;
  endtask
endmodule // mdio_host_model

//--- pma_pmd_control_status_regs_bench.sv
// self-checking bench for the attachment control/status block
`include "pma_ctrl_map.vh"
module pma_pmd_control_status_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, pin = 1'b1, link = 1'b1;
  logic tx_en = 1'b0, lrx_dv = 1'b0;
  logic [3:0] txd = 4'h0, lrxd = 4'h0;
  logic [15:0] d;
  wire mdc, h_oe, h_d, m_o, m_oe_n, line, rx_dv, ltx_en, c_rst, pd, lb;
  wire [3:0] rxd, ltxd;
  int err_count = 0, cmp_count = 0, i;
  // pull-up holds the line high when nobody drives it
  assign line = !m_oe_n ? m_o : h_oe ? h_d : 1'b1;
  always #2 clk_sys_i = ~clk_sys_i;
  pma_pmd_control_status_regs dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(line),
    .mdio_o(m_o), .mdio_oe_n_o(m_oe_n), .powerdown_default_pin_i(pin),
    .link_up_i(link), .tx_data_i(txd), .tx_en_i(tx_en),
    .line_rx_data_i(lrxd), .line_rx_dv_i(lrx_dv), .rx_data_o(rxd),
    .rx_dv_o(rx_dv), .line_tx_data_o(ltxd), .line_tx_en_o(ltx_en),
    .chip_reset_o(c_rst), .attach_soft_powerdown_o(pd),
    .local_loopback_enable_o(lb));
  mdio_host_model host (.line_i(line), .mdc_o(mdc), .oe_o(h_oe), .d_o(h_d));
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task chk(input string n, input [15:0] ex, input [15:0] got);
    cmp_count++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, ex, got);
    end
  endtask
  task acc(input [1:0] op, input [15:0] a, input [15:0] wd);
    host.frame(`OP_ADDRESS, `MMD_DEVAD, a, d);
    host.frame(op, `MMD_DEVAD, wd, d);
    // frames end off the bench's drive offset; realign to it
    step(1);
  endtask
  task rd(input string n, input [15:0] a, input [15:0] ex);
    acc(`OP_READ, a, 16'h0000);
    chk(n, ex, d);
  endtask
  // {valid, data} seen by the mac and by the line
  function [4:0] exp_rx(input l, input p, input [4:0] t, input [4:0] r);
    exp_rx = p ? 5'h00 : l ? t : r;
  endfunction
  function [4:0] exp_tx(input l, input p, input [4:0] t);
    exp_tx = (p || l) ? 5'h00 : t;
  endfunction
  task traffic(input l, input p);
    logic [4:0] x, y;
    repeat (16) begin
      txd = 4'($urandom);
      lrxd = 4'($urandom);
      tx_en = 1'($urandom);
      lrx_dv = 1'($urandom);
      x = exp_rx(l, p, {tx_en, txd}, {lrx_dv, lrxd});
      y = exp_tx(l, p, {tx_en, txd});
      step(1);
      chk("rx path", 16'(x), 16'({rx_dv, rxd}));
      chk("line tx", 16'(y), 16'({ltx_en, ltxd}));
    end
    tx_en = 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(64323));
    step(5);
    rst_i = 1'b0;
    step(8);
    chk("pd default", 16'h0001, 16'(pd));
    rd("ctl", `OFS_CONTROL, 16'h0800);
    traffic(1'b0, 1'b1);
    rd("sta first", `OFS_STATUS, `RST_STATUS);
    rd("sta up", `OFS_STATUS, 16'h0006);
    link = 1'b0;
    step(10);
    link = 1'b1;
    step(10);
    rd("sta drop", `OFS_STATUS, `RST_STATUS);
    rd("devs lo", `OFS_DEVS_LOW, `VAL_DEVS_LOW);
    rd("devs hi", `OFS_DEVS_HIGH, `VAL_DEVS_HIGH);
    acc(`OP_READ_INC, `OFS_DEVS_LOW, 16'h0000);
    chk("inc lo", `VAL_DEVS_LOW, d);
    host.frame(`OP_READ, `MMD_DEVAD, 16'h0000, d);
    chk("inc hi", `VAL_DEVS_HIGH, d);
    rd("unmapped", 16'h0003, 16'h0000);
    acc(`OP_WRITE, `OFS_STATUS, 16'hFFF9);
    rd("sta ro", `OFS_STATUS, 16'h0006);
    host.frame(`OP_ADDRESS, 5'h02, `OFS_CONTROL, d);
    host.frame(`OP_WRITE, 5'h02, 16'h0001, d);
    rd("foreign", `OFS_CONTROL, 16'h0800);
    acc(`OP_WRITE, `OFS_CONTROL, 16'h7FFF);
    rd("ctl rsvd", `OFS_CONTROL, 16'h0801);
    traffic(1'b1, 1'b1);
    acc(`OP_WRITE, `OFS_CONTROL, 16'h0001);
    traffic(1'b1, 1'b0);
    pin = 1'b0;
    acc(`OP_WRITE, `OFS_CONTROL, 16'h8801);
    chk("busy", 16'h0001, 16'(c_rst));
    for (i = 0; i < 400 && c_rst !== 1'b0; i++)
      step(1);
    if (i == 400) begin
      err_count++;
      report_and_stop;
    end
    step(8);
    rd("ctl soft", `OFS_CONTROL, 16'h0000);
    traffic(1'b0, 1'b0);
    // hardware reset in mid-run: pin default and status reset value again
    pin = 1'b1;
    step(4);
    rst_i = 1'b1;
    step(5);
    rst_i = 1'b0;
    step(8);
    rd("ctl hw", `OFS_CONTROL, 16'h0800);
    rd("sta hw", `OFS_STATUS, `RST_STATUS);
    report_and_stop;
  end
endmodule // pma_pmd_control_status_regs_bench
